// ---- pss_regs.svh ----
// constants for the pipelined synchronous sram port
// assumes inclusion by bare name from the package and the port module
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

`define PSS_ADDR_W 19
`define PSS_UPPER_W 17
`define PSS_LANE_W 9
`define PSS_LANES 2
`define PSS_WORD_W 18
`define PSS_MEM_WORDS 524288
`define PSS_BUF_DEPTH 2
`define PSS_SYNC_W 3
`define PSS_STRAP_RESET 1'b1

`endif

// ---- pss_pkg.sv ----
// types shared by the pipelined synchronous sram port
// assumes pss_regs.svh is reachable by bare name
`include "pss_regs.svh"

package pss_pkg;
    typedef enum logic [1:0] {
        burst_idle  = 2'b00,
        burst_read  = 2'b01,
        burst_write = 2'b10
    } pss_burst_e;

    typedef logic [`PSS_ADDR_W-1:0] pss_addr_t;
    typedef logic [`PSS_WORD_W-1:0] pss_word_t;
    typedef logic [`PSS_LANES-1:0] pss_lanes_t;
endpackage

// ---- pss_port.sv ----
// pipelined synchronous sram, 512k words of two nine-bit lanes, host port and array
// assumes the host drives all synchronous inputs from clk; sleep and strap are async pins
//
// Behaviour
// - write select at load sets whole burst direction
// - data moves two edges after command
// - everything clocked except output enable, sleep, strap
// - load with any chip select inactive deselects
// - deselect floats data bus two cycles later
// - second chip select is active high
// - output enable high floats pins asynchronously
// - load while selected captures address and controls
// - advance steps burst counter of running burst
// - address and write select ignored on advance
// - strap high interleaved, low linear order
// - sleep high enters standby, low normal
// - data in and out registered per lane
// - suspend freezes pipeline and burst registers as no edge; synchronisers and write buffer drain keep running
// - per-lane write enables, bytes written later
// - low address bits preset burst counter
// - counter wraps after fourth and continues
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_port
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // synchronous command pins
    input wire logic [`PSS_UPPER_W-1:0] address_upper,
    input wire logic burst_start_bit0,
    input wire logic burst_start_bit1,
    input wire logic write_select_low,
    input wire logic advance_or_load,
    input wire logic chip_select_first_low,
    input wire logic chip_select_second_high,
    input wire logic chip_select_third_low,
    input wire logic clock_suspend_low,
    input wire logic byte_write_lane_a_n,
    input wire logic byte_write_lane_b_n,
    // asynchronous pins
    input wire logic output_enable_low,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    // data lanes, split into in, out and enable
    input wire logic [`PSS_LANE_W-1:0] data_lane_a_in,
    output logic [`PSS_LANE_W-1:0] data_lane_a_out,
    output logic [`PSS_LANE_W-1:0] data_lane_a_oe,
    input wire logic [`PSS_LANE_W-1:0] data_lane_b_in,
    output logic [`PSS_LANE_W-1:0] data_lane_b_out,
    output logic [`PSS_LANE_W-1:0] data_lane_b_oe,
    // status
    output logic write_buffer_ready,
    output logic sleep_active
);

    ////////////////////////////////////////////////////////////////////////////////
    // asynchronous pin synchronisers
    logic [`PSS_SYNC_W-1:0] sleep_sync_q, strap_sync_q;
    logic sleep_q, sleep_d;
    logic interleave_q, interleave_d;

    always_comb
    begin
        // a change counts only once the second and third stages agree
        sleep_d = (sleep_sync_q[1] == sleep_sync_q[2]) ? sleep_sync_q[2] : sleep_q;
        interleave_d = (strap_sync_q[1] == strap_sync_q[2]) ? strap_sync_q[2] : interleave_q;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sleep_sync_q <= '0;
            strap_sync_q <= {`PSS_SYNC_W{`PSS_STRAP_RESET}};
            sleep_q <= 1'b0;
            interleave_q <= `PSS_STRAP_RESET;
        end
        else
        begin
            sleep_sync_q <= {sleep_sync_q[`PSS_SYNC_W-2:0], sleep_request};
            strap_sync_q <= {strap_sync_q[`PSS_SYNC_W-2:0], burst_order_strap};
            sleep_q <= sleep_d;
            interleave_q <= interleave_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // array and two-entry write buffer
    pss_pkg::pss_word_t mem_q [0:`PSS_MEM_WORDS-1];
    pss_pkg::pss_addr_t buf_addr_q [0:`PSS_BUF_DEPTH-1], buf_addr_d [0:`PSS_BUF_DEPTH-1];
    pss_pkg::pss_word_t buf_data_q [0:`PSS_BUF_DEPTH-1], buf_data_d [0:`PSS_BUF_DEPTH-1];
    pss_pkg::pss_lanes_t buf_be_q [0:`PSS_BUF_DEPTH-1], buf_be_d [0:`PSS_BUF_DEPTH-1];
    logic wr_ptr_q, wr_ptr_d;
    logic rd_ptr_q, rd_ptr_d;
    logic [1:0] fill_q, fill_d;
    logic ready_q, ready_d;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////////////
    // command pipeline
    pss_pkg::pss_burst_e burst_q, burst_d;
    logic [`PSS_UPPER_W-1:0] base_q, base_d;
    logic [1:0] start_q, start_d;
    logic [1:0] count_q, count_d;
    pss_pkg::pss_burst_e s1_op_q, s1_op_d;
    pss_pkg::pss_addr_t s1_addr_q, s1_addr_d;
    pss_pkg::pss_lanes_t s1_be_q, s1_be_d;
    pss_pkg::pss_burst_e s2_op_q, s2_op_d;
    pss_pkg::pss_addr_t s2_addr_q, s2_addr_d;
    pss_pkg::pss_lanes_t s2_be_q, s2_be_d;
    pss_pkg::pss_word_t dout_q, dout_d;
    logic drive_q, drive_d;

    always_comb
    begin
        logic run, selected, idx;
        logic [1:0] step;
        pss_pkg::pss_word_t rdata;
        run = ~clock_suspend_low;
        selected = ~chip_select_first_low & chip_select_second_high
            & ~chip_select_third_low;
        step = count_q + 2'h1;
        idx = 1'b0;
        rdata = mem_q[s2_addr_q];
        burst_d = burst_q;
        base_d = base_q;
        start_d = start_q;
        count_d = count_q;
        s1_op_d = s1_op_q;
        s1_addr_d = s1_addr_q;
        s1_be_d = s1_be_q;
        s2_op_d = s2_op_q;
        s2_addr_d = s2_addr_q;
        s2_be_d = s2_be_q;
        dout_d = dout_q;
        drive_d = drive_q;
        push = 1'b0;
        // buffered writes are newer than the array, so a read sees them oldest first
        for (int i = 0; i < `PSS_BUF_DEPTH; i++)
        begin
            idx = rd_ptr_q ^ i[0];
            if (i < 32'(fill_q) && buf_addr_q[idx] == s2_addr_q)
            begin
                for (int l = 0; l < `PSS_LANES; l++)
                begin
                    if (buf_be_q[idx][l])
                    begin
                        rdata[l*`PSS_LANE_W +: `PSS_LANE_W] =
                            buf_data_q[idx][l*`PSS_LANE_W +: `PSS_LANE_W];
                    end
                end
            end
        end
        if (run)
        begin
            s1_op_d = pss_pkg::burst_idle;
            s1_be_d = ~{byte_write_lane_b_n, byte_write_lane_a_n};
            if (!advance_or_load)
            begin
                if (selected && !sleep_q)
                begin
                    burst_d = write_select_low ? pss_pkg::burst_read : pss_pkg::burst_write;
                    base_d = address_upper;
                    start_d = {burst_start_bit1, burst_start_bit0};
                    count_d = 2'h0;
                    s1_op_d = burst_d;
                    s1_addr_d = {address_upper, burst_start_bit1, burst_start_bit0};
                end
                else
                begin
                    burst_d = pss_pkg::burst_idle;
                end
            end
            else if (burst_q != pss_pkg::burst_idle && !sleep_q)
            begin
                // the natural two-bit wrap restarts the sequence
                count_d = step;
                s1_op_d = burst_q;
                s1_addr_d = {base_q, interleave_q ? (start_q ^ step) : (start_q + step)};
            end
            s2_op_d = s1_op_q;
            s2_addr_d = s1_addr_q;
            s2_be_d = s1_be_q;
            drive_d = (s2_op_q == pss_pkg::burst_read);
            if (s2_op_q == pss_pkg::burst_read)
            begin
                dout_d = rdata;
            end
            // a write with both lanes masked is an aborted write
            push = (s2_op_q == pss_pkg::burst_write) && (|s2_be_q) && ready_q;
        end
    end

    always_comb
    begin
        for (int i = 0; i < `PSS_BUF_DEPTH; i++)
        begin
            buf_addr_d[i] = buf_addr_q[i];
            buf_data_d[i] = buf_data_q[i];
            buf_be_d[i] = buf_be_q[i];
        end
        // the array drain stalls during sleep, which is what lets the buffer fill
        pop = (fill_q != 2'h0) && !sleep_q;
        if (push)
        begin
            buf_addr_d[wr_ptr_q] = s2_addr_q;
            buf_data_d[wr_ptr_q] = {data_lane_b_in, data_lane_a_in};
            buf_be_d[wr_ptr_q] = s2_be_q;
        end
        wr_ptr_d = wr_ptr_q ^ push;
        rd_ptr_d = rd_ptr_q ^ pop;
        fill_d = fill_q + {1'b0, push} - {1'b0, pop};
        ready_d = (fill_d != 2'(`PSS_BUF_DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (pop)
        begin
            for (int l = 0; l < `PSS_LANES; l++)
            begin
                if (buf_be_q[rd_ptr_q][l])
                begin
                    mem_q[buf_addr_q[rd_ptr_q]][l*`PSS_LANE_W +: `PSS_LANE_W] <=
                        buf_data_q[rd_ptr_q][l*`PSS_LANE_W +: `PSS_LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < `PSS_BUF_DEPTH; i++)
            begin
                buf_addr_q[i] <= '0;
                buf_data_q[i] <= '0;
                buf_be_q[i] <= '0;
            end
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            fill_q <= 2'h0;
            ready_q <= 1'b1;
            burst_q <= pss_pkg::burst_idle;
            base_q <= '0;
            start_q <= 2'h0;
            count_q <= 2'h0;
            s1_op_q <= pss_pkg::burst_idle;
            s1_addr_q <= '0;
            s1_be_q <= '0;
            s2_op_q <= pss_pkg::burst_idle;
            s2_addr_q <= '0;
            s2_be_q <= '0;
            dout_q <= '0;
            drive_q <= 1'b0;
        end
        else
        begin
            buf_addr_q <= buf_addr_d;
            buf_data_q <= buf_data_d;
            buf_be_q <= buf_be_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            fill_q <= fill_d;
            ready_q <= ready_d;
            burst_q <= burst_d;
            base_q <= base_d;
            start_q <= start_d;
            count_q <= count_d;
            s1_op_q <= s1_op_d;
            s1_addr_q <= s1_addr_d;
            s1_be_q <= s1_be_d;
            s2_op_q <= s2_op_d;
            s2_addr_q <= s2_addr_d;
            s2_be_q <= s2_be_d;
            dout_q <= dout_d;
            drive_q <= drive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; the enable gate is deliberately combinational so output enable acts at once
    assign data_lane_a_out = dout_q[`PSS_LANE_W-1:0];
    assign data_lane_b_out = dout_q[`PSS_WORD_W-1:`PSS_LANE_W];
    assign data_lane_a_oe = {`PSS_LANE_W{drive_q & ~output_enable_low & ~sleep_q}};
    assign data_lane_b_oe = {`PSS_LANE_W{drive_q & ~output_enable_low & ~sleep_q}};
    assign write_buffer_ready = ready_q;
    assign sleep_active = sleep_q;

endmodule

// ---- pss_host_bus.sv ----
// host side of the data lanes: write beats and the resolved wire level
// assumes the bench raises host_en only while a write beat is due
`timescale 1ns/1ps

module pss_host_bus
(
    // clock
    input wire logic clk,
    // host write beat
    input wire logic host_en,
    input wire logic [17:0] host_word,
    // sram drivers
    input wire logic [8:0] a_out,
    input wire logic [8:0] a_oe,
    input wire logic [8:0] b_out,
    input wire logic [8:0] b_oe,
    // level on the wire
    output logic [17:0] wire_word
);
    logic [17:0] last_q;
    logic [17:0] drv;
    // undriven bits flip each cycle so a floating bus never reads as valid
    assign drv = {b_oe, a_oe};
    assign wire_word = host_en ? host_word : (drv & {b_out, a_out}) | (~drv & ~last_q);
    always_ff @(posedge clk)
        last_q <= wire_word;
endmodule

// ---- pss_port_props.sv ----
// pin-level assertions for the sram port
// assumes binding onto pss_port; one clock domain
`timescale 1ns/1ps

module pss_port_props
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // commands
    input wire logic write_select_low,
    input wire logic advance_or_load,
    input wire logic chip_select_first_low,
    input wire logic chip_select_second_high,
    input wire logic chip_select_third_low,
    input wire logic clock_suspend_low,
    input wire logic output_enable_low,
    input wire logic sleep_request,
    // outputs
    input wire logic [8:0] data_lane_a_out,
    input wire logic [8:0] data_lane_b_out,
    input wire logic [8:0] data_lane_a_oe,
    input wire logic [8:0] data_lane_b_oe,
    input wire logic sleep_active
);
    logic run, sel, off, on;
    assign run = !clock_suspend_low;
    assign sel = !chip_select_first_low && chip_select_second_high && !chip_select_third_low;
    assign off = (data_lane_a_oe | data_lane_b_oe) == '0;
    assign on = (data_lane_a_oe & data_lane_b_oe) == '1;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    sequence s_load(bit rd);
        run && !advance_or_load && sel && !sleep_active && write_select_low == rd;
    endsequence
    sequence s_run2;
        run ##1 run;
    endsequence
    sequence s_open;
        !output_enable_low && !sleep_active;
    endsequence
    sequence s_desel;
        run && !advance_or_load && !sel;
    endsequence
    sequence s_adv3;
        (run && advance_or_load)[*3];
    endsequence
    a_desel_float: assert property (s_desel ##1 s_run2 |=> off)
        else $error("bus driven after deselect");
    a_read_drive: assert property (s_load(1) ##1 s_run2 ##1 s_open |-> on)
        else $error("read data not driven");
    a_write_float: assert property (s_load(0) ##1 s_run2 |=> off)
        else $error("bus driven in write slot");
    a_burst_drive: assert property (s_load(1) ##1 s_adv3 ##1 s_open |-> on)
        else $error("burst beat not driven");
    a_oe_gate: assert property (output_enable_low || sleep_active |-> off)
        else $error("bus driven while disabled");
    a_suspend_hold: assert property (clock_suspend_low |=> $stable(data_lane_a_out))
        else $error("output moved on suspended edge");
    a_lane_b_hold: assert property (clock_suspend_low |=> $stable(data_lane_b_out))
        else $error("lane b moved on suspended edge");
    a_lanes_paired: assert property (data_lane_a_oe == data_lane_b_oe)
        else $error("lane enables differ");
    a_sleep_entry: assert property ((run && sleep_request)[*6] |-> sleep_active)
        else $error("standby not entered");
    a_sleep_exit: assert property ((run && !sleep_request)[*6] |-> !sleep_active)
        else $error("standby not left");
endmodule

bind pss_port pss_port_props props (.clk, .reset, .write_select_low, .advance_or_load,
    .chip_select_first_low, .chip_select_second_high, .chip_select_third_low,
    .clock_suspend_low, .output_enable_low, .sleep_request, .data_lane_a_out,
    .data_lane_b_out, .data_lane_a_oe, .data_lane_b_oe, .sleep_active);

// ---- tb_pipelined_sync_sram_port.sv ----
// self-checking bench: random bursts in both orders, suspend, deselect, standby
// assumes pss_host_bus resolves the lanes and the checker is bound
`timescale 1ns/1ps

module tb_pipelined_sync_sram_port;
    logic clk = 0;
    logic reset = 1;
    logic [16:0] au;
    logic b0, b1, wsl, adv, cs1, cs2, cs3, sus, byte_write_lane_a, byte_write_lane_b, oel, slp, strap, hen;
    logic [17:0] hw, wv;
    logic [8:0] ao, aoe, bo, boe;
    logic wbr, sa;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    logic [17:0] mem [logic [18:0]];
    logic [18:0] base;

    always #50 clk = ~clk;

    pss_port dut (.clk(clk), .reset(reset), .address_upper(au), .burst_start_bit0(b0),
        .burst_start_bit1(b1), .write_select_low(wsl), .advance_or_load(adv),
        .chip_select_first_low(cs1), .chip_select_second_high(cs2),
        .chip_select_third_low(cs3), .clock_suspend_low(sus), .byte_write_lane_a_n(byte_write_lane_a),
        .byte_write_lane_b_n(byte_write_lane_b), .output_enable_low(oel), .sleep_request(slp),
        .burst_order_strap(strap), .data_lane_a_in(wv[8:0]), .data_lane_a_out(ao),
        .data_lane_a_oe(aoe), .data_lane_b_in(wv[17:9]), .data_lane_b_out(bo),
        .data_lane_b_oe(boe), .write_buffer_ready(wbr), .sleep_active(sa));
    pss_host_bus host (.clk(clk), .host_en(hen), .host_word(hw), .a_out(ao), .a_oe(aoe),
        .b_out(bo), .b_oe(boe), .wire_word(wv));

    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // address of beat k of the burst loaded at base
    function automatic logic [18:0] addr_of(input int k);
        addr_of = {base[18:2], strap ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k)};
    endfunction

    // load, three advances, deselect at beat 4; address and select scrambled on advances
    task automatic burst(input logic wr, input logic [1:0] bw, input int ds, input logic hold);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            if (hold && i == 4)
            begin
                sus = 1;
                adv = 0;
                wsl = 0;
                @(negedge clk);
                sus = 0;
            end
            hen = wr && i >= 2 && i < 6;
            hw = 18'($urandom);
            if (hen && !bw[0])
                mem[addr_of(i - 2)][8:0] = hw[8:0];
            if (hen && !bw[1])
                mem[addr_of(i - 2)][17:9] = hw[17:9];
            if (!wr && i == 5)
            begin
                oel = 1;
                #1 chk_flag(aoe[0] | boe[0], 0);
                oel = 0;
                #1;
            end
            if (!wr && i >= 3 && i < 7)
            begin
                chk_flag(aoe[8] & boe[8], 1);
                chk_word({bo, ao}, mem[addr_of(i - 3)]);
            end
            if (i == 7)
                chk_flag(aoe[0] | boe[0], 0);
            adv = i != 0 && i != 4;
            {au, b1, b0, wsl} = adv ? 20'($urandom) : {base, !wr};
            {byte_write_lane_b, byte_write_lane_a} = bw;
            cs1 = i == 4 && ds == 0;
            cs2 = !(i == 4 && ds == 1);
            cs3 = i == 4 && ds == 2;
        end
    endtask

    initial
    begin
        {au, b0, b1, wsl, cs1, cs3, sus, byte_write_lane_a, byte_write_lane_b, oel, slp, hen} = '0;
        adv = 1;
        cs2 = 0;
        strap = 1;
        hw = '0;
        void'($urandom(32855));
        repeat (2) @(negedge clk);
        reset = 0;
        chk_flag(wbr, 1);
        for (int s = 0; s < 6; s++)
        begin
            // strap only moves while idle, past its synchroniser
            strap = s < 3;
            repeat (4) @(negedge clk);
            base = 19'($urandom);
            burst(1, 2'b00, s % 3, 0);
            burst(1, 2'($urandom), s % 3, 0);
            burst(0, 2'b11, s % 3, s[0]);
        end
        slp = 1;
        repeat (8) @(negedge clk);
        chk_flag(sa, 1);
        chk_flag(aoe[0], 0);
        slp = 0;
        repeat (8) @(negedge clk);
        chk_flag(sa, 0);
        end_of_test();
    end
endmodule
